// ---- core/hvpp_pkg.sv ----
package hvpp_pkg;

  // action selects applied on a load strobe pulse
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;

  // command byte encodings
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_FUSE_WR = 8'h40;
  localparam logic [7:0] CMD_LOCK_WR = 8'h20;
  localparam logic [7:0] CMD_FLASH_WR = 8'h10;
  localparam logic [7:0] CMD_EE_WR = 8'h11;
  localparam logic [7:0] CMD_SIG_RD = 8'h08;
  localparam logic [7:0] CMD_FUSE_RD = 8'h04;
  localparam logic [7:0] CMD_FLASH_RD = 8'h02;
  localparam logic [7:0] CMD_EE_RD = 8'h03;

  // entry pattern {page latch, action1, action0, byte select first}
  localparam logic [3:0] ENTRY_PATTERN = 4'h0;

  // fuse and lock layout and reset contents
  localparam int PRESERVE_BIT = 3;
  localparam logic [7:0] FUSE_LO_RST = 8'h62;
  localparam logic [7:0] FUSE_HI_RST = 8'hDF;
  localparam logic [7:0] FUSE_EXT_RST = 8'hF9;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // signature and calibration bytes, values arbitrary
  localparam logic [7:0] SIG_BYTE0 = 8'hA5;
  localparam logic [7:0] SIG_BYTE1 = 8'h5A;
  localparam logic [7:0] SIG_BYTE2 = 8'h3C;
  localparam logic [7:0] CAL_BYTE = 8'h80;

  // clock rate
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_US = 1000;

  // programmer pins, all synchronous to clk_sys
  typedef struct packed {
    logic page_latch_strobe;
    logic strobe_action_bit1;
    logic strobe_action_bit0;
    logic byte_select_first;
    logic byte_select_second;
    logic load_strobe;
    logic write_strobe_n;
    logic output_enable_n;
    logic [7:0] data_in;
  } prog_pins_type;

  typedef enum logic [2:0] {
    PH_OFF,
    PH_READY,
    PH_ERASE,
    PH_ERASE_LOCK,
    PH_PROG,
    PH_WAIT
  } phase_type;

  // microseconds to clock cycles, rounded down, at least one
  function automatic int us_to_cycles(input int us);
    int c;
    c = (us * NS_PER_US) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : us_to_cycles

endpackage : hvpp_pkg

// ---- core/pin_edges.sv ----
`timescale 1ns/100ps
module pin_edges #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_sync_b,
  // sampled levels
  input wire logic [WIDTH-1:0] level,
  // one-cycle edge pulses
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] prev; // level one clock ago

  // reset value is all ones: a strobe parked high at release is not a rise
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prev <= '1;
    end else begin
      prev <= level;
    end
  end

  // edge decode
  always_comb begin
    rise = level & ~prev;
    fall = ~level & prev;
  end

endmodule : pin_edges

// ---- core/hv_prog_port.sv ----
`timescale 1ns/100ps
module hv_prog_port
  import hvpp_pkg::*;
#(
  parameter int FLASH_AW = 13,
  parameter int PAGE_AW = 6,
  parameter int EE_AW = 9,
  parameter int EE_PAGE_AW = 2,
  parameter int ERASE_TIME_US = 10000,
  parameter int PROG_TIME_US = 5000,
  parameter int ERASE_CYC = us_to_cycles(ERASE_TIME_US),
  parameter int PROG_CYC = us_to_cycles(PROG_TIME_US)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // high voltage present on the reset pin
  input wire logic hv_on,
  // programmer strobes and data
  input wire prog_pins_type pins,
  // data bus return path
  output logic [7:0] data_out,
  output logic data_oe,
  // status
  output logic ready_busy_n,
  output logic prog_mode
);
  localparam int FLASH_WORDS = 1 << FLASH_AW;
  localparam int PAGE_WORDS = 1 << PAGE_AW;
  localparam int EE_BYTES = 1 << EE_AW;
  localparam int EE_PAGE = 1 << EE_PAGE_AW;
  localparam int WALK_MAX = (FLASH_WORDS > EE_BYTES) ? FLASH_WORDS : EE_BYTES;
  typedef struct packed {
    phase_type phase;
    logic [7:0] cmd;      // loaded command, kept until reloaded or set to no-op on mode entry
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] fuse_ext;
    logic [7:0] lock;
    logic [31:0] timer;   // busy time left
    logic [16:0] walk;    // erase or page copy index
    logic [7:0] dout;
    logic doe;
    logic rdy;
    logic mode;
  } core_type;
  core_type s;            // registered state
  core_type next_s;       // next state
  logic [1:0] rst_pipe;   // reset release synchroniser
  logic rst_sync_b;       // released reset for the edge and state registers, not the memories
  logic [4:0] rises;
  logic [4:0] falls;
  // memories, no reset: contents survive a port reset like real cells
  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0] ee_mem [EE_BYTES];
  logic [15:0] page_buf [PAGE_WORDS];
  logic [7:0] ee_buf [EE_PAGE];
  // memory write controls from the state logic
  logic fl_we;
  logic [FLASH_AW-1:0] fl_waddr;
  logic [15:0] fl_wdata;
  logic ee_we;
  logic [EE_AW-1:0] ee_waddr;
  logic [7:0] ee_wdata;
  logic pb_we;
  logic eb_we;
  // named edges, state decodes and addresses
  logic hv_rise;
  logic load_rise;
  logic latch_rise;
  logic write_fall;
  logic ready;
  logic preserve;
  logic [15:0] addr;
  logic [FLASH_AW-1:0] page_base;
  logic [EE_AW-1:0] ee_base;
  // async assert, release after two clocks
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe[1];
  pin_edges #(.WIDTH(5)) u_edges (
    .clk_sys(clk_sys),
    .rst_sync_b(rst_sync_b),
    .level({hv_on, pins.load_strobe, pins.page_latch_strobe,
            pins.write_strobe_n, pins.output_enable_n}),
    .rise(rises),
    .fall(falls)
  );
  assign hv_rise = rises[4];
  assign load_rise = rises[3];
  assign latch_rise = rises[2];
  assign write_fall = falls[1];
  assign ready = (s.phase == PH_READY);
  // preserve fuse acts as soon as programmed, 0 means programmed
  assign preserve = !s.fuse_hi[PRESERVE_BIT];
  assign addr = {s.addr_hi, s.addr_lo};
  // upper address bits pick the page, low bits the word in it
  assign page_base = {addr[FLASH_AW-1:PAGE_AW], {PAGE_AW{1'b0}}};
  assign ee_base = {addr[EE_AW-1:EE_PAGE_AW], {EE_PAGE_AW{1'b0}}};
  // read data for the loaded read command and byte selects
  function automatic logic [7:0] read_mux(input core_type c, input logic bs1,
                                          input logic bs2, input logic [15:0] w,
                                          input logic [7:0] e);
    logic [7:0] r;
    r = 8'h00;
    unique case (c.cmd)
      CMD_FLASH_RD: r = bs1 ? w[15:8] : w[7:0];
      CMD_EE_RD: r = e;
      CMD_SIG_RD: begin
        if (bs1) begin
          r = CAL_BYTE;
        end else begin
          unique case (c.addr_lo[1:0])
            2'h0: r = SIG_BYTE0;
            2'h1: r = SIG_BYTE1;
            2'h2: r = SIG_BYTE2;
            default: r = 8'h00; // no fourth signature byte
          endcase
        end
      end
      CMD_FUSE_RD: begin
        unique case ({bs2, bs1})
          2'h0: r = c.fuse_lo;
          2'h3: r = c.fuse_hi;
          2'h2: r = c.fuse_ext;
          2'h1: r = c.lock;
        endcase
      end
      default: r = 8'h00; // write commands read as zero
    endcase
    return r;
  endfunction : read_mux
  // state update
  always_comb begin
    next_s = s;
    fl_we = 1'b0;
    fl_waddr = s.walk[FLASH_AW-1:0];
    fl_wdata = ERASED_WORD;
    ee_we = 1'b0;
    ee_waddr = s.walk[EE_AW-1:0];
    ee_wdata = ERASED_BYTE;
    pb_we = 1'b0;
    eb_we = 1'b0;
    unique case (s.phase)
      PH_OFF: begin
        // mode entered only if pattern held at high voltage rise
        if (hv_rise && ({pins.page_latch_strobe, pins.strobe_action_bit1,
            pins.strobe_action_bit0, pins.byte_select_first} == ENTRY_PATTERN)) begin
          next_s.phase = PH_READY;
          next_s.cmd = CMD_NOP;
        end
      end
      PH_READY: begin
        if (load_rise) begin
          unique case ({pins.strobe_action_bit1, pins.strobe_action_bit0})
            ACT_ADDR: begin
              if (pins.byte_select_first) begin
                next_s.addr_hi = pins.data_in;
              end else begin
                next_s.addr_lo = pins.data_in;
              end
            end
            ACT_DATA: begin
              if (pins.byte_select_first) begin
                next_s.data_hi = pins.data_in;
              end else begin
                next_s.data_lo = pins.data_in;
              end
            end
            ACT_CMD: next_s.cmd = pins.data_in;
            default: ; // idle action
          endcase
        end
        // page latch moves loaded bytes into the buffer
        if (latch_rise) begin
          pb_we = (s.cmd == CMD_FLASH_WR);
          eb_we = (s.cmd == CMD_EE_WR);
        end
        // write pulse runs the loaded command
        if (write_fall) begin
          next_s.walk = '0;
          unique case (s.cmd)
            CMD_ERASE: next_s.phase = PH_ERASE;
            CMD_FLASH_WR, CMD_EE_WR: next_s.phase = PH_PROG;
            CMD_FUSE_WR: begin
              unique case ({pins.byte_select_second, pins.byte_select_first})
                2'h1: next_s.fuse_hi = s.data_lo;
                2'h2: next_s.fuse_ext = s.data_lo;
                default: next_s.fuse_lo = s.data_lo;
              endcase
              next_s.timer = 32'(PROG_CYC);
              next_s.phase = PH_WAIT;
            end
            CMD_LOCK_WR: begin
              // lock bits only program (go to 0) here
              next_s.lock = s.lock & s.data_lo;
              next_s.timer = 32'(PROG_CYC);
              next_s.phase = PH_WAIT;
            end
            default: ; // reads and no-op do nothing on write
          endcase
        end
      end
      PH_ERASE: begin
        // one location per clock; fuses untouched
        fl_we = (int'(s.walk) < FLASH_WORDS);
        ee_we = (int'(s.walk) < EE_BYTES) && !preserve;
        next_s.walk = s.walk + 17'h00001;
        if (int'(s.walk) == WALK_MAX - 1) begin
          next_s.phase = PH_ERASE_LOCK;
        end
      end
      PH_ERASE_LOCK: begin
        // lock cleared only after the array is fully erased
        next_s.lock = LOCK_RST;
        next_s.timer = 32'(ERASE_CYC);
        next_s.phase = PH_WAIT;
      end
      PH_PROG: begin
        // copy page buffer into the addressed page
        if (s.cmd == CMD_FLASH_WR) begin
          fl_we = 1'b1;
          fl_waddr = page_base | FLASH_AW'(s.walk[PAGE_AW-1:0]);
          fl_wdata = page_buf[s.walk[PAGE_AW-1:0]];
          if (int'(s.walk) == PAGE_WORDS - 1) begin
            next_s.phase = PH_WAIT;
          end
        end else begin
          ee_we = 1'b1;
          ee_waddr = ee_base | EE_AW'(s.walk[EE_PAGE_AW-1:0]);
          ee_wdata = ee_buf[s.walk[EE_PAGE_AW-1:0]];
          if (int'(s.walk) == EE_PAGE - 1) begin
            next_s.phase = PH_WAIT;
          end
        end
        next_s.walk = s.walk + 17'h00001;
        next_s.timer = 32'(PROG_CYC);
      end
      PH_WAIT: begin
        // self-timed tail of the operation
        next_s.timer = s.timer - 32'h00000001;
        if (s.timer <= 32'h00000001) begin
          next_s.phase = PH_READY;
        end
      end
      default: next_s.phase = PH_OFF;
    endcase
    // dropping high voltage ends the mode from any phase
    if (!hv_on) begin
      next_s.phase = PH_OFF;
    end
    next_s.mode = (next_s.phase != PH_OFF);
    next_s.rdy = (next_s.phase == PH_READY);
    // drive only while enable is low in the mode, else release
    next_s.doe = next_s.mode && !pins.output_enable_n;
    next_s.dout = read_mux(s, pins.byte_select_first, pins.byte_select_second,
                           flash_mem[addr[FLASH_AW-1:0]], ee_mem[addr[EE_AW-1:0]]);
  end
  // state register
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s <= '{phase: PH_OFF, cmd: CMD_NOP, fuse_lo: FUSE_LO_RST, fuse_hi: FUSE_HI_RST,
             fuse_ext: FUSE_EXT_RST, lock: LOCK_RST, default: '0};
    end else begin
      s <= next_s;
    end
  end
  // memory arrays
  always_ff @(posedge clk_sys) begin
    if (fl_we) begin
      flash_mem[fl_waddr] <= fl_wdata;
    end
    if (ee_we) begin
      ee_mem[ee_waddr] <= ee_wdata;
    end
    if (pb_we) begin
      page_buf[s.addr_lo[PAGE_AW-1:0]] <= {s.data_hi, s.data_lo};
    end
    if (eb_we) begin
      ee_buf[s.addr_lo[EE_PAGE_AW-1:0]] <= s.data_lo;
    end
  end
  assign data_out = s.dout;
  assign data_oe = s.doe;
  assign ready_busy_n = s.rdy;
  assign prog_mode = s.mode;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_b);
  a_busy_on_erase: assert property (
    ready && hv_on && write_fall && s.cmd == CMD_ERASE |=> !ready_busy_n [*2])
    else $error("erase start did not pull ready low");
  a_bus_drive: assert property (
    prog_mode && hv_on && !pins.output_enable_n |=> data_oe)
    else $error("data bus not driven while enabled");
  a_bus_release: assert property (
    pins.output_enable_n |=> !data_oe) else $error("data bus driven while enable high");
  a_ready_source: assert property (
    $rose(ready_busy_n) |-> $past(s.phase) inside {PH_WAIT, PH_OFF})
    else $error("ready rose without finishing an operation");
  a_mode_exit: assert property (
    !hv_on |=> !prog_mode && !ready_busy_n) else $error("mode kept without high voltage");
  a_entry_pattern: assert property (
    !prog_mode && hv_rise && pins.page_latch_strobe |=> !prog_mode)
    else $error("mode entered with wrong pattern");
  a_cmd_load: assert property (
    ready && hv_on && load_rise && {pins.strobe_action_bit1, pins.strobe_action_bit0} == ACT_CMD
    |=> s.cmd == $past(pins.data_in))
    else $error("command byte not loaded");
  a_addr_high: assert property (
    ready && hv_on && load_rise && {pins.strobe_action_bit1, pins.strobe_action_bit0} == ACT_ADDR
    && pins.byte_select_first |=> s.addr_hi == $past(pins.data_in) && $stable(s.addr_lo))
    else $error("address high byte misrouted");
  a_cmd_kept: assert property (
    s.phase != PH_OFF && s.phase != PH_READY |=> $stable(s.cmd) && $stable(addr))
    else $error("command or address lost during operation");
  a_lock_order: assert property (
    s.phase == PH_ERASE |=> $stable(s.lock) && $stable(s.fuse_hi))
    else $error("lock or fuse changed during array erase");
  a_ee_preserved: assert property (
    s.phase == PH_ERASE && preserve |-> !ee_we)
    else $error("eeprom erased despite preserve fuse");
  a_page_latch: assert property (
    ready && hv_on && latch_rise && s.cmd == CMD_FLASH_WR
    |=> page_buf[$past(s.addr_lo[PAGE_AW-1:0])] == $past({s.data_hi, s.data_lo}))
    else $error("page latch did not store the data word");
  a_fuse_ext_read: assert property (
    ready && hv_on && s.cmd == CMD_FUSE_RD && pins.byte_select_second
    && !pins.byte_select_first |=> data_out == $past(s.fuse_ext))
    else $error("extended fuse byte not selected");
  c_erase_done: cover property (s.phase == PH_ERASE_LOCK ##1 s.phase == PH_WAIT);
  c_page_prog: cover property (s.phase == PH_PROG && s.cmd == CMD_FLASH_WR);
  c_ee_prog: cover property (s.phase == PH_PROG && s.cmd == CMD_EE_WR);
  c_fuse_read: cover property (data_oe && s.cmd == CMD_FUSE_RD);
endmodule : hv_prog_port

// ---- verif/prg_model.sv ----
`timescale 1ns/100ps
module prg_model
  import hvpp_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // device return path
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  // pins seen by the device
  output prog_pins_type pins
);
  prog_pins_type ctl; // levels the programmer sets
  logic [7:0] drv; // byte the programmer offers
  logic [7:0] bus; // resolved bus level
  logic [7:0] last; // bus level one cycle back

  // idle levels hold the entry pattern from time zero
  initial begin
    ctl = '0;
    ctl.write_strobe_n = 1'b1;
    ctl.output_enable_n = 1'b1;
    drv = 8'h00;
  end

  // no pull on the bus: a floating bus toggles so stale data never matches
  always_comb begin
    if (data_oe) begin
      bus = data_out;
    end else if (ctl.output_enable_n) begin
      bus = drv;
    end else begin
      bus = ~last;
    end
  end

  // history for the floating level
  always_ff @(posedge clk_sys) begin
    last <= bus;
  end

  // strobes from ctl, data from the resolved bus
  assign pins = {ctl[15:8], bus};

  // n clock edges, then the fixed drive delay
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  // one load strobe pulse with action, byte select and byte
  task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] val);
    {ctl.strobe_action_bit1, ctl.strobe_action_bit0} = act;
    ctl.byte_select_first = bs1;
    drv = val;
    ctl.load_strobe = 1'b1;
    step(2);
    ctl.load_strobe = 1'b0;
    step(1);
  endtask : load

  // page latch pulse, high byte selected while it acts
  task automatic latch();
    ctl.byte_select_first = 1'b1;
    ctl.page_latch_strobe = 1'b1;
    step(2);
    ctl.page_latch_strobe = 1'b0;
    step(1);
  endtask : latch

  // negative write pulse with both byte selects
  task automatic write(input logic bs1, input logic bs2);
    ctl.byte_select_first = bs1;
    ctl.byte_select_second = bs2;
    ctl.write_strobe_n = 1'b0;
    step(2);
    ctl.write_strobe_n = 1'b1;
    step(1);
  endtask : write

  // output enable window; bus released by the programmer meanwhile
  task automatic read(input logic bs1, input logic bs2, output logic [7:0] v,
                      output logic oe_on, output logic oe_off);
    ctl.byte_select_first = bs1;
    ctl.byte_select_second = bs2;
    ctl.output_enable_n = 1'b0;
    step(3);
    v = bus;
    oe_on = data_oe;
    ctl.output_enable_n = 1'b1;
    step(2);
    oe_off = data_oe;
  endtask : read
endmodule : prg_model

// ---- verif/hv_prog_port_tb_top.sv ----
`timescale 1ns/100ps
module hv_prog_port_tb_top
  import hvpp_pkg::*;
;
  // quiet time after high voltage, in 5 ns cycles
  localparam int CMD_WAIT = 300 * 1000 / 5;
  logic clk_sys; // 200 MHz
  logic rst_b; // active low reset
  logic hv_on; // high voltage on reset pin
  prog_pins_type pins; // programmer pins
  logic [7:0] data_out; // device read data
  logic data_oe; // device drives bus
  logic ready_busy_n; // ready flag
  logic prog_mode; // in programming mode
  int err_count; // mismatches
  int comparisons; // checks made
  logic [7:0] v; // byte read back
  logic oe1; // bus driven during read
  logic oe0; // bus driven after read

  // small memories and short timers keep erase walks brief
  hv_prog_port #(.FLASH_AW(7), .EE_AW(4), .ERASE_CYC(4), .PROG_CYC(4)) DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .hv_on(hv_on), .pins(pins),
    .data_out(data_out), .data_oe(data_oe), .ready_busy_n(ready_busy_n),
    .prog_mode(prog_mode));

  prg_model PRG (.clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe), .pins(pins));

  // clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // byte compare
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  // flag compare
  task automatic chkb(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chkb

  // counts and verdict
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // bounded wait for ready; a hang ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_busy_n !== 1'b1 && n < 2000) begin
      PRG.step(1);
      n++;
    end
    if (ready_busy_n !== 1'b1) begin
      err_count++;
      $display("Error ready_busy_n expected 1 seen %b", ready_busy_n);
      wrap_up();
    end
  endtask : wait_ready

  // command load
  task automatic cmd(input logic [7:0] c);
    PRG.load(ACT_CMD, 1'b0, c);
  endtask : cmd

  // read one byte and judge the bus drive around it
  task automatic rd(input logic bs1, input logic bs2, input string what,
                    input logic [7:0] exp);
    PRG.read(bs1, bs2, v, oe1, oe0);
    chk8(what, exp, v);
    chkb("bus driven in read", 1'b1, oe1);
    chkb("bus released", 1'b0, oe0);
  endtask : rd

  // write pulse that must raise busy at once, then wait it out
  task automatic run_write(input logic bs1, input logic bs2);
    PRG.write(bs1, bs2);
    chkb("busy after write", 1'b0, ready_busy_n);
    wait_ready();
  endtask : run_write

  // wrong pattern refused, then a clean entry
  task automatic test_entry();
    PRG.ctl.page_latch_strobe = 1'b1;
    hv_on = 1'b1;
    PRG.step(3);
    chkb("mode on wrong pattern", 1'b0, prog_mode);
    hv_on = 1'b0;
    PRG.ctl.page_latch_strobe = 1'b0;
    PRG.step(2);
    hv_on = 1'b1;
    PRG.step(2);
    chkb("mode on entry", 1'b1, prog_mode);
    chkb("ready on entry", 1'b1, ready_busy_n);
    PRG.step(CMD_WAIT);
    $display("test_entry done");
  endtask : test_entry

  // erase, page write into page 1, readback by byte and page
  task automatic test_flash();
    cmd(CMD_ERASE);
    run_write(1'b0, 1'b0);
    cmd(CMD_FLASH_WR);
    PRG.load(ACT_ADDR, 1'b1, 8'h00);
    PRG.load(ACT_ADDR, 1'b0, 8'h41);
    PRG.load(ACT_DATA, 1'b0, 8'h34);
    PRG.load(ACT_DATA, 1'b1, 8'h12);
    PRG.latch();
    run_write(1'b0, 1'b0);
    cmd(CMD_FLASH_RD);
    rd(1'b0, 1'b0, "flash low byte", 8'h34);
    rd(1'b1, 1'b0, "flash high byte", 8'h12);
    PRG.load(ACT_ADDR, 1'b0, 8'h01);
    rd(1'b0, 1'b0, "flash page 0", ERASED_BYTE);
    $display("test_flash done");
  endtask : test_flash

  // fuses, preserve fuse, eeprom and lock across an erase
  task automatic test_nv();
    cmd(CMD_FUSE_RD);
    rd(1'b0, 1'b0, "fuse low", FUSE_LO_RST);
    rd(1'b0, 1'b1, "fuse ext", FUSE_EXT_RST);
    rd(1'b1, 1'b1, "fuse high", FUSE_HI_RST);
    cmd(CMD_FUSE_WR);
    PRG.load(ACT_DATA, 1'b0, FUSE_HI_RST & ~(8'h01 << PRESERVE_BIT));
    run_write(1'b1, 1'b0);
    PRG.load(ACT_DATA, 1'b0, 8'hF8);
    run_write(1'b0, 1'b1);
    PRG.load(ACT_DATA, 1'b0, 8'h6E);
    run_write(1'b0, 1'b0);
    cmd(CMD_EE_WR);
    PRG.load(ACT_ADDR, 1'b0, 8'h06);
    PRG.load(ACT_DATA, 1'b0, 8'h5A);
    PRG.latch();
    run_write(1'b0, 1'b0);
    cmd(CMD_EE_RD);
    rd(1'b0, 1'b0, "eeprom byte", 8'h5A);
    cmd(CMD_LOCK_WR);
    PRG.load(ACT_DATA, 1'b0, 8'hFC);
    run_write(1'b0, 1'b0);
    cmd(CMD_FUSE_RD);
    rd(1'b1, 1'b0, "lock written", 8'hFC);
    cmd(CMD_ERASE);
    run_write(1'b0, 1'b0);
    cmd(CMD_FUSE_RD);
    rd(1'b1, 1'b0, "lock erased", LOCK_RST);
    rd(1'b1, 1'b1, "fuse kept", FUSE_HI_RST & ~(8'h01 << PRESERVE_BIT));
    rd(1'b0, 1'b1, "fuse ext kept", 8'hF8);
    rd(1'b0, 1'b0, "fuse low kept", 8'h6E);
    cmd(CMD_EE_RD);
    rd(1'b0, 1'b0, "eeprom preserved", 8'h5A);
    $display("test_nv done");
  endtask : test_nv

  // signature and calibration; idle action must not touch the command
  task automatic test_sig();
    cmd(CMD_SIG_RD);
    PRG.load(ACT_ADDR, 1'b1, 8'h00);
    PRG.load(ACT_ADDR, 1'b0, 8'h02);
    PRG.load(2'h3, 1'b0, CMD_ERASE);
    rd(1'b0, 1'b0, "signature 2", SIG_BYTE2);
    PRG.load(ACT_ADDR, 1'b0, 8'h00);
    rd(1'b0, 1'b0, "signature 0", SIG_BYTE0);
    rd(1'b1, 1'b0, "calibration", CAL_BYTE);
    $display("test_sig done");
  endtask : test_sig

  // drop high voltage while the bus is enabled
  task automatic test_exit();
    PRG.ctl.output_enable_n = 1'b0;
    PRG.step(2);
    hv_on = 1'b0;
    PRG.step(2);
    chkb("mode after exit", 1'b0, prog_mode);
    chkb("ready after exit", 1'b0, ready_busy_n);
    chkb("bus after exit", 1'b0, data_oe);
    PRG.ctl.output_enable_n = 1'b1;
    $display("test_exit done");
  endtask : test_exit

  // main sequence
  initial begin
    err_count = 0;
    comparisons = 0;
    rst_b = 1'b0;
    hv_on = 1'b0;
    PRG.step(2);
    chkb("ready in reset", 1'b0, ready_busy_n);
    chkb("bus in reset", 1'b0, data_oe);
    rst_b = 1'b1;
    PRG.step(4);
    test_entry();
    test_flash();
    test_nv();
    test_sig();
    test_exit();
    wrap_up();
  end
endmodule : hv_prog_port_tb_top
